/* rtl/pas_regs.sv */
// Register front end for status, advertisement and partner ability words
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Status bit 15 reads constant 0: no T4 mode.
// - Status bits 14 to 11 read constant 1: four speed/duplex abilities.
// - Status bit 5 shows negotiation complete, resets to 0.
// - Status bit 4 sets on remote fault, clears when status read.
// - Status bit 3 resets to 1, drops after a link failure.
// - Status bit 2 shows valid link now, resets to 0.
// - Status bit 1 shows jabber detected.
// - Status bit 0 reads constant 1: extended registers present.
// - Advertisement bit 15 read-only 0: primary page sent.
// - Advertisement bit 14 set when device acknowledges partner word.
// - Advertisement bit 13 writable, resets 0, advertises fault ability.
// - Advertisement bit 10 read-only 1: pause flow control.
// - Advertisement bits 8 to 5 writable, reset to 1.
// - Advertisement bits 4 to 0 writable selector, reset 00001.
// - Partner register read-only; bit 14 shows partner acknowledge.
// - Partner bit 13 shows partner remote fault.
// - Partner bit 10 shows partner flow control, resets 0.
// - Partner bits 8 to 5 show partner abilities, reset 0.
// - Partner bits 4 to 0 hold received selector, reset 00000.
// - Software reset returns all three registers to defaults.
////////////////////////////////////////////////////////////////////////////////
module pas_regs (
	input  wire logic                sys_clk,
	input  wire logic                rst_n,
	input  wire pas_pkg::pas_addr_t  reg_addr,
	input  wire logic                reg_wr_en,
	input  wire logic                reg_rd_en,
	input  wire pas_pkg::pas_word_t  reg_wdata,
	output var  pas_pkg::pas_word_t  reg_rdata,
	output var  logic                reg_rd_valid,
	input  wire logic                soft_reset,
	input  wire logic                an_complete,
	input  wire logic                remote_fault_event,
	input  wire logic                link_fail_event,
	input  wire logic                link_valid,
	input  wire logic                jabber_detect,
	input  wire logic                local_ack,
	input  wire logic                partner_page_valid,
	input  wire pas_pkg::pas_word_t  partner_page
);
	pas_if ifc ();

	pas_pkg::pas_word_t adv;
	pas_pkg::pas_word_t next_adv;
	pas_pkg::pas_word_t adv_word;
	pas_pkg::pas_word_t next_rdata;
	logic               ack;
	logic               rd_stat;
	logic               rd_adv;
	logic               rd_part;
	logic               wr_adv;

	////////////////////////////////////////////////////////////////////////////////
	// Address decode

	function automatic logic hit(input pas_pkg::pas_addr_t a,
		input pas_pkg::pas_addr_t off);
		return a == off;
	endfunction

	assign rd_stat = reg_rd_en && hit(reg_addr, pas_pkg::OFF_STATUS);
	assign rd_adv  = reg_rd_en && hit(reg_addr, pas_pkg::OFF_ADVERT);
	assign rd_part = reg_rd_en && hit(reg_addr, pas_pkg::OFF_PARTNER);
	assign wr_adv  = reg_wr_en && hit(reg_addr, pas_pkg::OFF_ADVERT);

	////////////////////////////////////////////////////////////////////////////////
	// Status and partner parts

	assign ifc.soft_reset = soft_reset;
	assign ifc.status_rd  = rd_stat;
	assign ifc.rf_event   = remote_fault_event;
	assign ifc.link_fail  = link_fail_event;
	assign ifc.link_ok    = link_valid;
	assign ifc.jabber     = jabber_detect;
	assign ifc.an_done    = an_complete;
	assign ifc.page_valid = partner_page_valid;
	assign ifc.page_in    = partner_page;

	pas_status u_status (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.ifc     (ifc.stat)
	);

	pas_partner u_partner (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.ifc     (ifc.part)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Advertisement register

	// Only writable fields are stored
	assign next_adv = wr_adv ? (reg_wdata & pas_pkg::ADV_WR_MASK) : adv;

	assign adv_word = pas_pkg::ADV_FIXED | adv
		| (pas_pkg::pas_word_t'(ack) << pas_pkg::AD_ACK_BIT);

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			adv <= pas_pkg::ADV_RESET;
			ack <= pas_pkg::FLAG_RESET;
		end else if (soft_reset) begin
			adv <= pas_pkg::ADV_RESET;
			ack <= pas_pkg::FLAG_RESET;
		end else begin
			adv <= next_adv;
			ack <= local_ack;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read port

	assign next_rdata = rd_stat ? ifc.status_word
		: rd_adv ? adv_word
		: rd_part ? ifc.partner_word
		: 16'h0000;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata    <= 16'h0000;
			reg_rd_valid <= 1'b0;
		end else begin
			reg_rdata    <= next_rdata;
			reg_rd_valid <= reg_rd_en;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);

	sequence s_stat_read;
		rd_stat && !soft_reset && !remote_fault_event;
	endsequence

	sequence s_adv_write;
		wr_adv && !soft_reset;
	endsequence

	sequence s_page_in;
		partner_page_valid && !soft_reset;
	endsequence

	sequence s_fail_seen;
		link_fail_event && !soft_reset;
	endsequence

	sequence s_hist_hold;
		!ifc.status_word[pas_pkg::ST_HIST_BIT] && !soft_reset;
	endsequence

	t4_zero_a: assert property (
		!ifc.status_word[pas_pkg::ST_T4_BIT])
		else $error("status T4 bit not zero");

	abil_ones_a: assert property (
		ifc.status_word[pas_pkg::ST_ABIL_HI:pas_pkg::ST_ABIL_LO] == 4'hF)
		else $error("status ability bits not all one");

	done_follow_a: assert property (
		!soft_reset |=> ifc.status_word[pas_pkg::ST_DONE_BIT] == $past(an_complete))
		else $error("negotiation done bit not following engine");

	rf_set_a: assert property (
		remote_fault_event && !soft_reset |=>
		ifc.status_word[pas_pkg::ST_RF_BIT])
		else $error("remote fault not latched");

	rf_sticky_a: assert property (
		ifc.status_word[pas_pkg::ST_RF_BIT] && !rd_stat && !soft_reset |=>
		ifc.status_word[pas_pkg::ST_RF_BIT])
		else $error("remote fault dropped without a read");

	rf_clear_a: assert property (
		s_stat_read |=> !ifc.status_word[pas_pkg::ST_RF_BIT])
		else $error("remote fault not cleared by status read");

	rf_seen_a: assert property (
		s_stat_read ##0 ifc.status_word[pas_pkg::ST_RF_BIT] |=>
		reg_rdata[pas_pkg::ST_RF_BIT])
		else $error("read did not return pending remote fault");

	hist_drop_a: assert property (
		s_fail_seen |=> !ifc.status_word[pas_pkg::ST_HIST_BIT])
		else $error("link history not cleared by failure");

	hist_hold_a: assert property (
		s_hist_hold |=> !ifc.status_word[pas_pkg::ST_HIST_BIT] [*1] ##1
		(soft_reset || !ifc.status_word[pas_pkg::ST_HIST_BIT]
		|| $past(soft_reset)))
		else $error("link history recovered without reset");

	hist_rise_a: assert property (
		$rose(ifc.status_word[pas_pkg::ST_HIST_BIT]) |-> $past(soft_reset))
		else $error("link history set without reset");

	link_follow_a: assert property (
		!soft_reset |=> ifc.status_word[pas_pkg::ST_LINK_BIT] == $past(link_valid))
		else $error("link bit not following link state");

	jab_follow_a: assert property (
		!soft_reset |=>
		ifc.status_word[pas_pkg::ST_JAB_BIT] == $past(jabber_detect))
		else $error("jabber bit not following detector");

	ext_one_a: assert property (
		ifc.status_word[pas_pkg::ST_EXT_BIT])
		else $error("extended capability bit not one");

	np_zero_a: assert property (
		!adv_word[pas_pkg::AD_NP_BIT])
		else $error("next page flag not zero");

	ack_follow_a: assert property (
		!soft_reset |=> adv_word[pas_pkg::AD_ACK_BIT] == $past(local_ack))
		else $error("acknowledge bit not following engine");

	ack_nowrite_a: assert property (
		s_adv_write ##0 !local_ack |=> !adv_word[pas_pkg::AD_ACK_BIT])
		else $error("acknowledge bit taken from a write");

	rf_write_a: assert property (
		s_adv_write |=>
		adv_word[pas_pkg::AD_RF_BIT] == $past(reg_wdata[pas_pkg::AD_RF_BIT]))
		else $error("remote fault advert not written");

	pause_one_a: assert property (
		adv_word[pas_pkg::AD_PAUSE_BIT])
		else $error("pause ability bit not one");

	abil_write_a: assert property (
		s_adv_write |=> adv_word[pas_pkg::AD_ABIL_HI:pas_pkg::AD_ABIL_LO]
		== $past(reg_wdata[pas_pkg::AD_ABIL_HI:pas_pkg::AD_ABIL_LO]))
		else $error("ability advert not written");

	sel_write_a: assert property (
		s_adv_write |=> adv_word[pas_pkg::AD_SEL_HI:pas_pkg::AD_SEL_LO]
		== $past(reg_wdata[pas_pkg::AD_SEL_HI:pas_pkg::AD_SEL_LO]))
		else $error("selector not written");

	adv_hold_a: assert property (
		!wr_adv && !soft_reset |=> (adv_word & pas_pkg::ADV_WR_MASK)
		== $past(adv_word & pas_pkg::ADV_WR_MASK))
		else $error("advert changed without a write");

	page_take_a: assert property (
		s_page_in |=>
		ifc.partner_word == ($past(partner_page) & pas_pkg::PART_MASK))
		else $error("partner page not captured");

	page_rf_a: assert property (
		s_page_in ##0 partner_page[pas_pkg::AD_RF_BIT] |=>
		ifc.partner_word[pas_pkg::AD_RF_BIT])
		else $error("partner remote fault lost");

	page_pause_a: assert property (
		s_page_in |=> ifc.partner_word[pas_pkg::AD_PAUSE_BIT]
		== $past(partner_page[pas_pkg::AD_PAUSE_BIT]))
		else $error("partner pause bit wrong");

	page_abil_a: assert property (
		s_page_in |=> ifc.partner_word[pas_pkg::AD_ABIL_HI:pas_pkg::AD_ABIL_LO]
		== $past(partner_page[pas_pkg::AD_ABIL_HI:pas_pkg::AD_ABIL_LO]))
		else $error("partner abilities wrong");

	page_sel_a: assert property (
		s_page_in |=> ifc.partner_word[pas_pkg::AD_SEL_HI:pas_pkg::AD_SEL_LO]
		== $past(partner_page[pas_pkg::AD_SEL_HI:pas_pkg::AD_SEL_LO]))
		else $error("partner selector wrong");

	page_hold_a: assert property (
		!partner_page_valid && !soft_reset |=> $stable(ifc.partner_word))
		else $error("partner page changed without a page");

	soft_rst_a: assert property (
		soft_reset |=> adv_word == (pas_pkg::ADV_RESET | pas_pkg::ADV_FIXED)
		&& ifc.partner_word == pas_pkg::PART_RESET
		&& ifc.status_word[pas_pkg::ST_HIST_BIT]
		&& !ifc.status_word[pas_pkg::ST_RF_BIT]
		&& !ifc.status_word[pas_pkg::ST_DONE_BIT]
		&& !ifc.status_word[pas_pkg::ST_LINK_BIT])
		else $error("software reset left a register changed");

	wr_soft_a: assert property (
		wr_adv && soft_reset |=>
		(adv_word & pas_pkg::ADV_WR_MASK) == pas_pkg::ADV_RESET)
		else $error("advert write taken during software reset");

	resv_zero_a: assert property (
		(adv_word & ~(pas_pkg::ADV_WR_MASK | pas_pkg::ADV_FIXED
		| 16'h4000)) == 16'h0000
		&& (ifc.partner_word & ~pas_pkg::PART_MASK) == 16'h0000
		&& ifc.status_word[10:6] == 5'h00)
		else $error("reserved bit not zero");

	rd_latency_a: assert property (
		reg_rd_en |=> reg_rd_valid)
		else $error("read valid not returned next cycle");

	rd_idle_a: assert property (
		!reg_rd_en |=>
		!reg_rd_valid && reg_rdata == 16'h0000)
		else $error("read port not idle without a read");

	rd_stat_a: assert property (
		rd_stat |=> reg_rdata == $past(ifc.status_word))
		else $error("status read data wrong");

	rd_adv_a: assert property (
		rd_adv |=> reg_rdata == $past(adv_word))
		else $error("advert read data wrong");

	rf_race_a: assert property (
		rd_stat && remote_fault_event && !soft_reset |=>
		ifc.status_word[pas_pkg::ST_RF_BIT])
		else $error("remote fault lost when read in event cycle");

	rd_unmapped_a: assert property (
		reg_rd_en && !rd_stat && !rd_adv && !rd_part |=>
		reg_rdata == 16'h0000)
		else $error("unmapped read not zero");

	rd_part_a: assert property (
		rd_part |=> reg_rdata == $past(ifc.partner_word))
		else $error("partner read data wrong");

	ro_write_a: assert property (
		reg_wr_en && !wr_adv && !soft_reset && !partner_page_valid |=>
		$stable(ifc.partner_word))
		else $error("write reached a read-only register");
endmodule
`default_nettype wire

/* pkg/pas_pkg.sv */
// Constants and types for the autonegotiation status register bank
`default_nettype none
package pas_pkg;
	typedef logic [15:0] pas_word_t;
	typedef logic [7:0]  pas_addr_t;

	// Register offsets
	localparam pas_addr_t OFF_STATUS  = 8'h64;
	localparam pas_addr_t OFF_ADVERT  = 8'h66;
	localparam pas_addr_t OFF_PARTNER = 8'h68;

	// Status field positions
	localparam int ST_T4_BIT   = 15;
	localparam int ST_ABIL_HI  = 14;
	localparam int ST_ABIL_LO  = 11;
	localparam int ST_DONE_BIT = 5;
	localparam int ST_RF_BIT   = 4;
	localparam int ST_HIST_BIT = 3;
	localparam int ST_LINK_BIT = 2;
	localparam int ST_JAB_BIT  = 1;
	localparam int ST_EXT_BIT  = 0;

	// Advertisement and partner field positions
	localparam int AD_NP_BIT    = 15;
	localparam int AD_ACK_BIT   = 14;
	localparam int AD_RF_BIT    = 13;
	localparam int AD_PAUSE_BIT = 10;
	localparam int AD_ABIL_HI   = 8;
	localparam int AD_ABIL_LO   = 5;
	localparam int AD_SEL_HI    = 4;
	localparam int AD_SEL_LO    = 0;

	// Fixed parts, masks and reset values
	localparam pas_word_t ST_FIXED    = 16'h7801;
	localparam pas_word_t ADV_FIXED   = 16'h0400;
	localparam pas_word_t ADV_WR_MASK = 16'h21FF;
	localparam pas_word_t ADV_RESET   = 16'h01E1;
	localparam pas_word_t PART_MASK   = 16'hE5FF;
	localparam pas_word_t PART_RESET  = 16'h0000;
	localparam logic      HIST_RESET  = 1'b1;
	localparam logic      FLAG_RESET  = 1'b0;
endpackage
`default_nettype wire

/* pkg/pas_if.sv */
// Carrier between the register front end and its status and partner parts
`timescale 1ns/1ps
`default_nettype none
interface pas_if;
	logic               soft_reset;
	logic               status_rd;
	logic               rf_event;
	logic               link_fail;
	logic               link_ok;
	logic               jabber;
	logic               an_done;
	logic               page_valid;
	pas_pkg::pas_word_t page_in;
	pas_pkg::pas_word_t status_word;
	pas_pkg::pas_word_t partner_word;

	modport ctl (output soft_reset, status_rd, rf_event, link_fail, link_ok,
		jabber, an_done, page_valid, page_in, input status_word, partner_word);
	modport stat (input soft_reset, status_rd, rf_event, link_fail, link_ok,
		jabber, an_done, output status_word);
	modport part (input soft_reset, page_valid, page_in, output partner_word);
endinterface
`default_nettype wire

/* rtl/pas_status.sv */
// Basic mode status word with sticky fault and link history
`timescale 1ns/1ps
`default_nettype none
module pas_status (
	input wire logic sys_clk,
	input wire logic rst_n,
	pas_if.stat      ifc
);
	logic done_q;
	logic rfault;
	logic hist;
	logic link_q;
	logic jab_q;
	logic next_rfault;
	logic next_hist;

	assign next_rfault = ifc.rf_event | (rfault & ~ifc.status_rd);
	assign next_hist   = hist & ~ifc.link_fail;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			done_q <= pas_pkg::FLAG_RESET;
			rfault <= pas_pkg::FLAG_RESET;
			hist   <= pas_pkg::HIST_RESET;
			link_q <= pas_pkg::FLAG_RESET;
			jab_q  <= pas_pkg::FLAG_RESET;
		end else if (ifc.soft_reset) begin
			done_q <= pas_pkg::FLAG_RESET;
			rfault <= pas_pkg::FLAG_RESET;
			hist   <= pas_pkg::HIST_RESET;
			link_q <= pas_pkg::FLAG_RESET;
			jab_q  <= pas_pkg::FLAG_RESET;
		end else begin
			done_q <= ifc.an_done;
			rfault <= next_rfault;
			hist   <= next_hist;
			link_q <= ifc.link_ok;
			jab_q  <= ifc.jabber;
		end
	end

	// Fixed abilities plus live bits; reserved bits stay zero
	assign ifc.status_word = pas_pkg::ST_FIXED
		| (pas_pkg::pas_word_t'(done_q) << pas_pkg::ST_DONE_BIT)
		| (pas_pkg::pas_word_t'(rfault) << pas_pkg::ST_RF_BIT)
		| (pas_pkg::pas_word_t'(hist) << pas_pkg::ST_HIST_BIT)
		| (pas_pkg::pas_word_t'(link_q) << pas_pkg::ST_LINK_BIT)
		| (pas_pkg::pas_word_t'(jab_q) << pas_pkg::ST_JAB_BIT);
endmodule
`default_nettype wire

/* rtl/pas_partner.sv */
// Captured link partner ability page
`timescale 1ns/1ps
`default_nettype none
module pas_partner (
	input wire logic sys_clk,
	input wire logic rst_n,
	pas_if.part      ifc
);
	pas_pkg::pas_word_t page;
	pas_pkg::pas_word_t next_page;

	// Keep only implemented fields of a received page
	assign next_page = ifc.page_valid ? (ifc.page_in & pas_pkg::PART_MASK) : page;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			page <= pas_pkg::PART_RESET;
		end else if (ifc.soft_reset) begin
			page <= pas_pkg::PART_RESET;
		end else begin
			page <= next_page;
		end
	end

	assign ifc.partner_word = page;
endmodule
`default_nettype wire

/* sim/pas_link_model.sv */
// Remote station and negotiation engine driving the bank's event inputs
`timescale 1ns/1ps
`default_nettype none
module pas_link_model (
	output var  logic               an_complete,
	input  wire logic               sys_clk,
	output var  logic               remote_fault_event,
	output var  logic               link_fail_event,
	output var  logic               link_valid,
	output var  logic               jabber_detect,
	output var  logic               local_ack,
	output var  logic               partner_page_valid,
	output var  pas_pkg::pas_word_t partner_page
);
	initial begin
		{an_complete, link_valid, jabber_detect, local_ack} = 4'h0;
		remote_fault_event = 1'b0;
		link_fail_event = 1'b0;
		partner_page_valid = 1'b0;
		partner_page = 16'hA5A5;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Level conditions: completion, link, jabber, acknowledge
	task automatic set_levels(input logic [3:0] lv);
		@(posedge sys_clk);
		{an_complete, link_valid, jabber_detect, local_ack} <= lv;
	endtask

	// One-cycle remote fault event
	task automatic fault_event();
		@(posedge sys_clk);
		remote_fault_event <= 1'b1;
		@(posedge sys_clk);
		remote_fault_event <= 1'b0;
	endtask

	// One-cycle link failure event
	task automatic fail_event();
		@(posedge sys_clk);
		link_fail_event <= 1'b1;
		@(posedge sys_clk);
		link_fail_event <= 1'b0;
	endtask

	// Page strobe; page lines show the inverse once released
	task automatic send_page(input pas_pkg::pas_word_t w);
		@(posedge sys_clk);
		partner_page <= w;
		partner_page_valid <= 1'b1;
		@(posedge sys_clk);
		partner_page_valid <= 1'b0;
		partner_page <= ~w;
	endtask
endmodule
`default_nettype wire

/* sim/testbench.sv */
// Self-checking bench for the status, advertisement and partner register bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic               sys_clk = 1'b0;
	logic               rst_n = 1'b0;
	pas_pkg::pas_addr_t reg_addr = 8'h00;
	logic               reg_wr_en = 1'b0;
	logic               reg_rd_en = 1'b0;
	pas_pkg::pas_word_t reg_wdata = 16'h0000;
	pas_pkg::pas_word_t reg_rdata;
	logic               reg_rd_valid;
	logic               soft_reset = 1'b0;
	logic               an_complete;
	logic               remote_fault_event;
	logic               link_fail_event;
	logic               link_valid;
	logic               jabber_detect;
	logic               local_ack;
	logic               partner_page_valid;
	pas_pkg::pas_word_t partner_page;
	int                 failures = 0;
	int                 n_checks = 0;
	int                 seed = 65;
	logic               e_done, e_rf, e_hist, e_link, e_jab, e_ack;
	pas_pkg::pas_word_t e_adv, e_part, w;

	always #50 sys_clk = ~sys_clk;

	pas_regs uut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid), .soft_reset(soft_reset),
		.an_complete(an_complete), .remote_fault_event(remote_fault_event),
		.link_fail_event(link_fail_event), .link_valid(link_valid),
		.jabber_detect(jabber_detect), .local_ack(local_ack),
		.partner_page_valid(partner_page_valid), .partner_page(partner_page));

	pas_link_model link (.sys_clk(sys_clk), .an_complete(an_complete),
		.remote_fault_event(remote_fault_event), .link_fail_event(link_fail_event),
		.link_valid(link_valid), .jabber_detect(jabber_detect), .local_ack(local_ack),
		.partner_page_valid(partner_page_valid), .partner_page(partner_page));

	////////////////////////////////////////////////////////////////////////////////
	// Expected words
	function automatic pas_pkg::pas_word_t st_exp();
		return {1'b0, 4'hF, 5'h00, e_done, e_rf, e_hist, e_link, e_jab, 1'b1};
	endfunction
	function automatic pas_pkg::pas_word_t adv_exp();
		return {1'b0, e_ack, e_adv[13], 2'b00, 1'b1, 1'b0, e_adv[8:0]};
	endfunction
	function automatic pas_pkg::pas_word_t part_exp();
		return {e_part[15:13], 2'b00, e_part[10], 1'b0, e_part[8:0]};
	endfunction
	function automatic void defaults();
		{e_done, e_rf, e_link, e_jab, e_ack} = 5'h00;
		e_hist = 1'b1;
		e_adv = 16'h01E1;
		e_part = 16'h0000;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Compare, access and closing tasks
	task automatic chk(input pas_pkg::pas_word_t got, input pas_pkg::pas_word_t exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t ns: word %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_flag(input logic got, input logic exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t ns: read valid %b, expected %b", $time, got, exp);
		end
	endtask
	task automatic reg_wr(input pas_pkg::pas_addr_t a, input pas_pkg::pas_word_t d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr_en <= 1'b1;
		@(posedge sys_clk);
		reg_wr_en <= 1'b0;
		reg_wdata <= ~d;
	endtask
	task automatic rd_chk(input pas_pkg::pas_addr_t a, input pas_pkg::pas_word_t exp);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd_en <= 1'b1;
		@(posedge sys_clk);
		reg_rd_en <= 1'b0;
		#1;
		chk_flag(reg_rd_valid, 1'b1);
		chk(reg_rdata, exp);
	endtask
	task automatic pulse_soft_reset();
		@(posedge sys_clk);
		soft_reset <= 1'b1;
		@(posedge sys_clk);
		soft_reset <= 1'b0;
	endtask
	task automatic conclude();
		$display("Checks %0d, failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// Hang guard
	initial begin
		repeat (20000) @(posedge sys_clk);
		failures++;
		$display("[ERR] %0t ns: run did not finish", $time);
		conclude();
	end

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		defaults();
		repeat (6) @(posedge sys_clk);
		rst_n <= 1'b1;
		rd_chk(pas_pkg::OFF_STATUS, st_exp());
		rd_chk(pas_pkg::OFF_ADVERT, adv_exp());
		rd_chk(pas_pkg::OFF_PARTNER, part_exp());
		rd_chk(8'h6A, 16'h0000);
		// Writes to read-only words
		reg_wr(pas_pkg::OFF_STATUS, 16'hFFFF);
		reg_wr(pas_pkg::OFF_PARTNER, 16'hFFFF);
		rd_chk(pas_pkg::OFF_STATUS, st_exp());
		rd_chk(pas_pkg::OFF_PARTNER, part_exp());
		// Advertisement writes: corners then random
		for (int i = 0; i < 12; i++) begin
			w = (i == 0) ? 16'hFFFF : ((i == 1) ? 16'h0000 : 16'($random(seed)));
			reg_wr(pas_pkg::OFF_ADVERT, w);
			e_adv = w;
			rd_chk(pas_pkg::OFF_ADVERT, adv_exp());
		end
		// Every level combination
		for (int i = 0; i < 16; i++) begin
			{e_done, e_link, e_jab, e_ack} = 4'(i);
			link.set_levels(4'(i));
			rd_chk(pas_pkg::OFF_STATUS, st_exp());
			rd_chk(pas_pkg::OFF_ADVERT, adv_exp());
		end
		// Sticky fault cleared by a status read
		link.fault_event();
		e_rf = 1'b1;
		rd_chk(pas_pkg::OFF_STATUS, st_exp());
		e_rf = 1'b0;
		rd_chk(pas_pkg::OFF_STATUS, st_exp());
		// Fault event in the cycle of a status read: set wins
		fork
			link.fault_event();
			rd_chk(pas_pkg::OFF_STATUS, st_exp());
		join
		e_rf = 1'b1;
		rd_chk(pas_pkg::OFF_STATUS, st_exp());
		e_rf = 1'b0;
		rd_chk(pas_pkg::OFF_STATUS, st_exp());
		// Link history stays low after a failure
		link.fail_event();
		e_hist = 1'b0;
		rd_chk(pas_pkg::OFF_STATUS, st_exp());
		link.set_levels(4'h4);
		{e_done, e_link, e_jab, e_ack} = 4'h4;
		rd_chk(pas_pkg::OFF_STATUS, st_exp());
		// Partner pages: all ones then random
		for (int i = 0; i < 8; i++) begin
			e_part = (i == 0) ? 16'hFFFF : 16'($random(seed));
			link.send_page(e_part);
			rd_chk(pas_pkg::OFF_PARTNER, part_exp());
		end
		reg_wr(pas_pkg::OFF_PARTNER, ~e_part);
		rd_chk(pas_pkg::OFF_PARTNER, part_exp());
		// Software reset with fault pending and history low
		reg_wr(pas_pkg::OFF_ADVERT, 16'h2000);
		link.set_levels(4'h0);
		link.fault_event();
		pulse_soft_reset();
		defaults();
		rd_chk(pas_pkg::OFF_STATUS, st_exp());
		rd_chk(pas_pkg::OFF_ADVERT, adv_exp());
		rd_chk(pas_pkg::OFF_PARTNER, part_exp());
		// Software reset beats events, a page and a write in its cycle
		fork
			pulse_soft_reset();
			link.fault_event();
			link.fail_event();
			link.send_page(16'hFFFF);
			reg_wr(pas_pkg::OFF_ADVERT, 16'h0000);
		join
		rd_chk(pas_pkg::OFF_STATUS, st_exp());
		rd_chk(pas_pkg::OFF_ADVERT, adv_exp());
		rd_chk(pas_pkg::OFF_PARTNER, part_exp());
		conclude();
	end
endmodule
`default_nettype wire
